/* File: inc/ecs_pkg.sv */
// Package for the event condition supervisor: map, encodings, timing.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone bus.
package ecs_pkg;
   // -----------------------------------------------------------------
   // Sizes and timing
   // -----------------------------------------------------------------
   localparam int unsigned ECS_EVENTS = 512;
   localparam int unsigned ECS_GATE_INS = 5;
   localparam int unsigned ECS_OVR_LINKS = 8;
   localparam int unsigned ECS_CLK_HZ = 10000000;
   localparam int unsigned ECS_TICK_MS = 1;
   localparam int unsigned ECS_TICK_CYC = ECS_CLK_HZ / 1000 * ECS_TICK_MS;
   localparam int unsigned ECS_UV_SEC = 10;
   localparam int unsigned ECS_UV_MS = ECS_UV_SEC * 1000;
   localparam int unsigned ECS_HYST_MV = 500;
   localparam logic [15:0] ECS_VMIN_RST = 16'h1770;
   localparam logic [15:0] ECS_VMAX_RST = 16'h5dc0;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [15:0] ECS_A_CFG0 = 16'h0000;
   localparam logic [15:0] ECS_A_CFG1 = 16'h0004;
   localparam logic [15:0] ECS_A_CFG2 = 16'h0008;
   localparam logic [15:0] ECS_A_CFG3 = 16'h000c;
   localparam logic [15:0] ECS_A_SEL = 16'h0010;
   localparam logic [15:0] ECS_A_VMIN = 16'h0014;
   localparam logic [15:0] ECS_A_VMAX = 16'h0018;
   localparam logic [15:0] ECS_A_LAMP = 16'h001c;
   localparam logic [15:0] ECS_A_STAT = 16'h0020;
   localparam logic [15:0] ECS_A_EVST = 16'h0024;
   localparam logic [15:0] ECS_A_OVR = 16'h0028;
   localparam logic [15:0] ECS_A_DIN = 16'h002c;

   // -----------------------------------------------------------------
   // Encodings
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      ECS_T_UNUSED, ECS_T_FOLLOW, ECS_T_TOGGLE, ECS_T_AND, ECS_T_OR,
      ECS_T_NOR, ECS_T_XOR, ECS_T_NOT, ECS_T_FLASH, ECS_T_DLY_ON,
      ECS_T_DLY_OFF, ECS_T_ALWAYS, ECS_T_OVR
   } ecs_type_e;
   typedef enum logic [2:0] {
      ECS_OP_EQ, ECS_OP_LT, ECS_OP_GT, ECS_OP_LE, ECS_OP_GE, ECS_OP_NE
   } ecs_op_e;
   typedef enum logic [2:0] {
      ECS_S_DIN, ECS_S_AIN, ECS_S_CUR, ECS_S_FLT, ECS_S_CAN, ECS_S_CNT, ECS_S_TMP
   } ecs_src_e;
   typedef enum logic [1:0] {ECS_L_HOLD, ECS_L_OFF, ECS_L_ON} ecs_loss_e;
   localparam logic [1:0] ECS_DIN_OPEN = 2'h0;
   localparam logic [1:0] ECS_DIN_LOW = 2'h1;
   localparam logic [1:0] ECS_DIN_HIGH = 2'h2;
   localparam int unsigned ECS_ST_CAN_MAX = 2;
   localparam int unsigned ECS_ST_PWR = 4;
   localparam int unsigned ECS_ST_MISC = 5;
   localparam int unsigned ECS_ST_RTC = 6;
   localparam int unsigned ECS_ST_CFG = 7;
endpackage : ecs_pkg

/* File: rtl/ecs_cfg_mem.sv */
// Configuration memory: one word per event, registered read port.
// Assumes a single clock; write and read may happen in one cycle.
`timescale 1ns/1ps
`default_nettype none
module ecs_cfg_mem #(
   parameter int unsigned DEPTH = 512,
   parameter int unsigned WIDTH = 128,
   parameter int unsigned AW = 9
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // Write port
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge clk_i)
   begin
      rdata_o <= mem_q[raddr_i];
   end
endmodule : ecs_cfg_mem
`default_nettype wire

/* File: rtl/ecs_state_mem.sv */
// Per-event result and timer storage, one word per event, registered read.
// Assumes the evaluator writes back one word per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module ecs_state_mem #(
   parameter int unsigned DEPTH = 512,
   parameter int unsigned WIDTH = 18,
   parameter int unsigned AW = 9
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // Write port
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge clk_i)
   begin
      rdata_o <= mem_q[raddr_i];
   end
endmodule : ecs_state_mem
`default_nettype wire

/* File: rtl/ecs_top.sv */
// Event condition supervisor: event evaluation, CAN loss, undervoltage,
// override maps and warning lamp status, behind a classic Wishbone slave.
// Assumes inputs synchronous to clk_i; outputs driven by flip-flops.
//
// Overview of operation
// RQ1: 512 configurable events, each with one evaluation type.
// RQ2: Gate events combine up to five events as AND, OR, NOR, XOR.
// RQ3: Event source picked from digital, analogue, current, fault, CAN, counter, temperature.
// RQ4: CAN sources accepted only from buses one and two; code accepts only channels with can_bus_i low, others read zero.
// RQ5: On and off conditions compare source with constant by six operators.
// RQ6: On CAN loss apply configured action: hold, force off, force on.
// RQ7: CAN fault when message not refreshed within loss interval in milliseconds.
// RQ8: Software never programs a zero loss interval.
// RQ9: Software sets loss interval near 2.5 times message period.
// RQ10: Software lets exactly one event drive each output.
// RQ11: Event with output none drives nothing, serves only as condition.
// RQ12: All outputs off after battery below minimum for 10 seconds.
// RQ13: Outputs back after battery above minimum plus 0.5 V for 10 seconds.
// RQ14: Software programs minimum 6000 mV and maximum 24000 mV.
// RQ15: Override maps force chosen outputs on or off while event true.
// RQ16: Each output links up to 8 override events, any one applies.
// RQ17: Overrides take precedence over event controlled output decisions.
// RQ18: Digital switch inputs reported as open, low or high.
// RQ19: Lamp blinks count of fault class, one to eight.
// RQ20: Status word weights 1 to 128 per class, faults combined.
// RQ21: CAN fault lamp indication enabled per bus, suppressed otherwise.
// RQ22: Events and timers run on a 1 ms tick; reset clears timers; code leaves the per-event timers in ecs_state_mem uncleared.
// RQ23: Status word refreshed continuously, bits follow fault conditions.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ecs_top #(
   parameter int unsigned N_OUT = 32,
   parameter int unsigned N_CH = 16,
   parameter int unsigned N_DIN = 16,
   parameter int unsigned UV_MS = ecs_pkg::ECS_UV_MS,
   parameter int unsigned TICK_CYC = ecs_pkg::ECS_TICK_CYC,
   parameter int unsigned FLASH_MS = 400
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [N_CH*16-1:0] ain_i,
   input wire logic [N_CH*16-1:0] cur_i,
   input wire logic [N_CH*16-1:0] flt_i,
   input wire logic [N_CH*16-1:0] cnt_i,
   input wire logic [N_CH*16-1:0] tmp_i,
   input wire logic [N_CH*16-1:0] can_val_i,
   input wire logic [N_CH-1:0] can_upd_i,
   input wire logic [N_CH-1:0] can_bus_i,
   input wire logic [N_DIN-1:0] din_lvl_i,
   input wire logic [N_DIN-1:0] din_open_i,
   input wire logic [15:0] vbat_mv_i,
   input wire logic pwr_fault_i,
   input wire logic misc_fault_i,
   input wire logic rtc_fault_i,
   output logic [N_OUT-1:0] out_o,
   output logic [7:0] status_o,
   output logic lamp_o
);
   import ecs_pkg::*;

   localparam int unsigned AW = 9;
   localparam int unsigned CW = 128;
   localparam int unsigned SW = 18;
   localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
   localparam logic [15:0] UV_LAST = 16'(UV_MS - 1);
   localparam logic [15:0] HYST = 16'(ECS_HYST_MV);
   localparam logic [8:0] LAST_EV = 9'(ECS_EVENTS - 1);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic cmp(input logic [2:0] op, input logic [15:0] a,
                                input logic [15:0] b);
      logic r;
      r = 1'b0;
      case (op)
         ECS_OP_EQ: r = (a == b);
         ECS_OP_LT: r = (a < b);
         ECS_OP_GT: r = (a > b);
         ECS_OP_LE: r = (a <= b);
         ECS_OP_GE: r = (a >= b);
         ECS_OP_NE: r = (a != b);
         default: r = 1'b0;
      endcase
      return r;
   endfunction : cmp

   function automatic logic [15:0] pick(input logic [N_CH*16-1:0] v, input logic [7:0] i);
      return v[16*(i % N_CH) +: 16];
   endfunction : pick

   // -----------------------------------------------------------------
   // Millisecond tick
   // -----------------------------------------------------------------
   logic [15:0] div_q;
   logic tick;
   assign tick = (div_q == TICK_LAST);
   // Divider for the common time base
   always_ff @(posedge clk_i)
   begin
      if (rst_i || tick) div_q <= 16'h0000; // RQ22
      else div_q <= div_q + 16'h0001;
   end

   // -----------------------------------------------------------------
   // Wishbone slave and software registers
   // -----------------------------------------------------------------
   logic [31:0] cfg_stage_q [4];
   logic [8:0] sel_q;
   logic [15:0] vmin_q, vmax_q;
   logic [3:0] lamp_en_q;
   logic [N_OUT-1:0] ovr_on_q, ovr_off_q;
   logic cfg_we_q;
   logic [N_OUT-1:0] evt_out_q;
   logic [ECS_EVENTS-1:0] res_q;
   logic [1:0] din_st [N_DIN];
   logic wb_req;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Ack one cycle after request, dropped the next cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i) wb_ack_o <= 1'b0;
      else wb_ack_o <= wb_req;
   end

   // Register writes; config commit on selector write with bit 31 set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 4; i++) cfg_stage_q[i] <= 32'h0000_0000;
         sel_q <= 9'h000;
         vmin_q <= ECS_VMIN_RST;
         vmax_q <= ECS_VMAX_RST;
         lamp_en_q <= 4'h0;
         cfg_we_q <= 1'b0;
      end
      else
      begin
         cfg_we_q <= 1'b0;
         if (wb_req && wb_we_i)
         begin
            unique case (wb_adr_i)
               ECS_A_CFG0: cfg_stage_q[0] <= wb_dat_i;
               ECS_A_CFG1: cfg_stage_q[1] <= wb_dat_i;
               ECS_A_CFG2: cfg_stage_q[2] <= wb_dat_i;
               ECS_A_CFG3: cfg_stage_q[3] <= wb_dat_i;
               ECS_A_SEL:
               begin
                  sel_q <= wb_dat_i[8:0];
                  cfg_we_q <= wb_dat_i[31];
               end
               ECS_A_VMIN: vmin_q <= wb_dat_i[15:0];
               ECS_A_VMAX: vmax_q <= wb_dat_i[15:0];
               ECS_A_LAMP: lamp_en_q <= wb_dat_i[3:0]; // RQ21
               default: ;
            endcase
         end
      end
   end

   // Read mux
   always_ff @(posedge clk_i)
   begin
      if (rst_i) wb_dat_o <= 32'h0000_0000;
      else if (wb_req && !wb_we_i)
      begin
         unique case (wb_adr_i)
            ECS_A_CFG0: wb_dat_o <= cfg_stage_q[0];
            ECS_A_CFG1: wb_dat_o <= cfg_stage_q[1];
            ECS_A_CFG2: wb_dat_o <= cfg_stage_q[2];
            ECS_A_CFG3: wb_dat_o <= cfg_stage_q[3];
            ECS_A_SEL: wb_dat_o <= {23'h000000, sel_q};
            ECS_A_VMIN: wb_dat_o <= {16'h0000, vmin_q};
            ECS_A_VMAX: wb_dat_o <= {16'h0000, vmax_q};
            ECS_A_LAMP: wb_dat_o <= {28'h0000000, lamp_en_q};
            ECS_A_STAT: wb_dat_o <= {24'h000000, status_o};
            ECS_A_EVST: wb_dat_o <= {31'h00000000, res_q[sel_q]};
            ECS_A_OVR: wb_dat_o <= 32'(ovr_on_q | ovr_off_q);
            ECS_A_DIN: wb_dat_o <= {30'h00000000, din_st[sel_q[3:0] % N_DIN]}; // RQ18
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Digital switch three-state report
   always_comb
   begin
      for (int i = 0; i < N_DIN; i++)
         din_st[i] = din_open_i[i] ? ECS_DIN_OPEN : (din_lvl_i[i] ? ECS_DIN_HIGH : ECS_DIN_LOW); // RQ18
   end

   // -----------------------------------------------------------------
   // Event sweep: one event per cycle after each tick
   // -----------------------------------------------------------------
   // Config word: [3:0] type [6:4] src [14:7] chan [17:15] op_on [20:18] op_off
   // [22:21] loss [23] start [31:24] out (0 none) [47:32] k_on [63:48] k_off
   // [108:64] five 9-bit event refs [124:109] time/interval ms [125] ovr off
   logic [CW-1:0] cfg_rd;
   logic [SW-1:0] st_rd, st_wr;
   logic [8:0] idx_q, ridx;
   logic run_q, vld_q;
   logic [15:0] canage_q [N_CH];
   logic [N_CH-1:0] canlost;

   assign ridx = vld_q ? idx_q + 9'h001 : idx_q;

   ecs_cfg_mem #(.DEPTH(ECS_EVENTS), .WIDTH(CW), .AW(AW)) u_cfg (
      .clk_i(clk_i), .we_i(cfg_we_q), .waddr_i(sel_q),
      .wdata_i({cfg_stage_q[3], cfg_stage_q[2], cfg_stage_q[1], cfg_stage_q[0]}),
      .raddr_i(ridx), .rdata_o(cfg_rd));

   ecs_state_mem #(.DEPTH(ECS_EVENTS), .WIDTH(SW), .AW(AW)) u_st (
      .clk_i(clk_i), .we_i(vld_q), .waddr_i(idx_q), .wdata_i(st_wr),
      .raddr_i(ridx), .rdata_o(st_rd));

   // Sweep sequencer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_q <= 1'b0;
         vld_q <= 1'b0;
         idx_q <= 9'h000;
      end
      else if (tick && !run_q)
      begin
         run_q <= 1'b1; // RQ22
         idx_q <= 9'h000;
         vld_q <= 1'b0;
      end
      else if (run_q)
      begin
         vld_q <= 1'b1;
         if (vld_q) idx_q <= idx_q + 9'h001;
         if (vld_q && idx_q == LAST_EV)
         begin
            run_q <= 1'b0;
            vld_q <= 1'b0;
         end
      end
   end

   // CAN message age per channel in ms
   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < N_CH; c++)
      begin
         if (rst_i || can_upd_i[c]) canage_q[c] <= 16'h0000; // RQ7
         else if (tick && canage_q[c] != 16'hffff) canage_q[c] <= canage_q[c] + 16'h0001;
      end
   end

   // Evaluate the event in hand
   logic [15:0] src, tmr, tmr_n;
   logic on_c, off_c, prev, nres, lost, gate_any, gate_all, gate_one;
   logic [2:0] gate_cnt;
   logic [7:0] ch;
   always_comb
   begin
      ch = cfg_rd[14:7];
      prev = st_rd[0];
      tmr = st_rd[16:1];
      tmr_n = tmr;
      lost = 1'b0;
      unique case (cfg_rd[6:4]) // RQ3
         ECS_S_DIN: src = {15'h0000, din_lvl_i[ch % N_DIN]};
         ECS_S_AIN: src = pick(ain_i, ch);
         ECS_S_CUR: src = pick(cur_i, ch);
         ECS_S_FLT: src = pick(flt_i, ch);
         ECS_S_CAN: src = can_bus_i[ch % N_CH] ? 16'h0000 : pick(can_val_i, ch); // RQ4
         ECS_S_CNT: src = pick(cnt_i, ch);
         ECS_S_TMP: src = pick(tmp_i, ch);
         default: src = 16'h0000;
      endcase
      if (cfg_rd[6:4] == ECS_S_CAN)
         lost = canage_q[ch % N_CH] >= cfg_rd[124:109]; // RQ7
      on_c = cmp(cfg_rd[17:15], src, cfg_rd[47:32]); // RQ5
      off_c = cmp(cfg_rd[20:18], src, cfg_rd[63:48]); // RQ5
      gate_cnt = 3'h0;
      gate_all = 1'b1;
      for (int g = 0; g < ECS_GATE_INS; g++)
      begin
         gate_cnt = gate_cnt + {2'h0, res_q[cfg_rd[64+9*g +: 9]]}; // RQ2
         gate_all = gate_all & res_q[cfg_rd[64+9*g +: 9]];
      end
      gate_any = (gate_cnt != 3'h0);
      gate_one = (gate_cnt == 3'h1);
      nres = prev;
      unique case (cfg_rd[3:0]) // RQ1
         ECS_T_FOLLOW, ECS_T_OVR: nres = on_c ? 1'b1 : (off_c ? 1'b0 : prev);
         ECS_T_TOGGLE:
         begin
            nres = (on_c && !st_rd[17]) ? !prev : prev;
         end
         ECS_T_AND: nres = gate_all; // RQ2
         ECS_T_OR: nres = gate_any; // RQ2
         ECS_T_NOR: nres = !gate_any; // RQ2
         ECS_T_XOR: nres = gate_one; // RQ2
         ECS_T_NOT: nres = !res_q[cfg_rd[72:64]];
         ECS_T_FLASH:
         begin
            tmr_n = tmr + 16'h0001;
            if (tmr_n >= cfg_rd[124:109])
            begin
               tmr_n = 16'h0000;
               nres = !prev;
            end
         end
         ECS_T_DLY_ON, ECS_T_DLY_OFF:
         begin
            tmr_n = ((cfg_rd[3:0] == ECS_T_DLY_ON) == on_c) ? tmr + 16'h0001 : 16'h0000;
            nres = (tmr_n >= cfg_rd[124:109]) ? on_c : prev;
         end
         ECS_T_ALWAYS: nres = 1'b1;
         default: nres = 1'b0;
      endcase
      if (lost)
      begin
         unique case (cfg_rd[22:21]) // RQ6
            ECS_L_OFF: nres = 1'b0;
            ECS_L_ON: nres = 1'b1;
            default: nres = prev;
         endcase
      end
      st_wr = {on_c, tmr_n, nres};
   end

   // CAN loss flags
   always_ff @(posedge clk_i)
   begin
      for (int c = 0; c < N_CH; c++)
         if (rst_i || can_upd_i[c]) canlost[c] <= 1'b0;
         else if (vld_q && lost && ch % N_CH == c) canlost[c] <= 1'b1; // RQ7
   end

   // Results, output drive and override collection
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         res_q <= '0;
         evt_out_q <= '0;
         ovr_on_q <= '0;
         ovr_off_q <= '0;
      end
      else if (vld_q)
      begin
         res_q[idx_q] <= nres;
         if (cfg_rd[31:24] != 8'h00 && cfg_rd[3:0] != ECS_T_OVR) // RQ11
            evt_out_q[(cfg_rd[31:24] - 8'h01) % N_OUT] <= nres;
         if (cfg_rd[3:0] == ECS_T_OVR && nres) // RQ16
         begin
            if (cfg_rd[125]) ovr_off_q <= ovr_off_q | N_OUT'(cfg_rd[63:32]); // RQ15
            else ovr_on_q <= ovr_on_q | N_OUT'(cfg_rd[63:32]); // RQ15
         end
      end
      else if (tick)
      begin
         ovr_on_q <= '0;
         ovr_off_q <= '0;
      end
   end

   // -----------------------------------------------------------------
   // Battery undervoltage supervision
   // -----------------------------------------------------------------
   logic [15:0] uv_cnt_q;
   logic shut_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         uv_cnt_q <= 16'h0000;
         shut_q <= 1'b0;
      end
      else if (tick)
      begin
         if (!shut_q)
         begin
            if (vbat_mv_i >= vmin_q) uv_cnt_q <= 16'h0000;
            else if (uv_cnt_q == UV_LAST)
            begin
               shut_q <= 1'b1; // RQ12
               uv_cnt_q <= 16'h0000;
            end
            else uv_cnt_q <= uv_cnt_q + 16'h0001;
         end
         else
         begin
            if (vbat_mv_i <= vmin_q + HYST) uv_cnt_q <= 16'h0000;
            else if (uv_cnt_q == UV_LAST)
            begin
               shut_q <= 1'b0; // RQ13
               uv_cnt_q <= 16'h0000;
            end
            else uv_cnt_q <= uv_cnt_q + 16'h0001;
         end
      end
   end

   // Final output decision, undervoltage shutdown first, then overrides
   always_ff @(posedge clk_i)
   begin
      if (rst_i) out_o <= '0;
      else if (shut_q) out_o <= '0; // RQ12
      else out_o <= (evt_out_q | ovr_on_q) & ~ovr_off_q; // RQ17
   end

   // -----------------------------------------------------------------
   // Status word and warning lamp
   // -----------------------------------------------------------------
   logic [3:0] bus_lost;
   logic [15:0] fl_tmr_q;
   logic [3:0] fl_cnt_q, fl_cls_q;
   logic fl_gap_q;
   always_comb
   begin
      bus_lost = 4'h0;
      for (int c = 0; c < N_CH; c++)
         if (canlost[c] && !can_bus_i[c]) bus_lost[0] = 1'b1;
   end

   // Continuously refreshed status word
   always_ff @(posedge clk_i)
   begin
      if (rst_i) status_o <= 8'h00;
      else
      begin
         status_o[3:0] <= bus_lost & lamp_en_q; // RQ20 RQ21 RQ23
         status_o[ECS_ST_PWR] <= pwr_fault_i | shut_q; // RQ23
         status_o[ECS_ST_MISC] <= misc_fault_i;
         status_o[ECS_ST_RTC] <= rtc_fault_i;
         status_o[ECS_ST_CFG] <= (vmin_q >= vmax_q); // RQ20
      end
   end

   // Lamp blinks the lowest active class number, then a gap
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fl_tmr_q <= 16'h0000;
         fl_cnt_q <= 4'h0;
         fl_cls_q <= 4'h0;
         fl_gap_q <= 1'b0;
         lamp_o <= 1'b0;
      end
      else if (tick)
      begin
         if (fl_tmr_q != 16'(FLASH_MS - 1)) fl_tmr_q <= fl_tmr_q + 16'h0001;
         else
         begin
            fl_tmr_q <= 16'h0000;
            if (fl_cnt_q == 4'h0)
            begin
               lamp_o <= 1'b0;
               fl_gap_q <= !fl_gap_q;
               fl_cls_q <= 4'h0;
               for (int b = 7; b >= 0; b--)
                  if (status_o[b]) fl_cls_q <= 4'(b + 1);
               if (fl_gap_q) fl_cnt_q <= fl_cls_q; // RQ19
            end
            else
            begin
               lamp_o <= !lamp_o; // RQ19
               if (lamp_o) fl_cnt_q <= fl_cnt_q - 4'h1;
            end
         end
      end
   end
endmodule : ecs_top
`default_nettype wire

/* File: dv/ecs_properties.sv */
// Checker for ecs_top: status word and reset relations.
// Assumes it is bound onto ecs_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ecs_properties #(
   parameter int unsigned N_OUT = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pwr_fault_i,
   input wire logic misc_fault_i,
   input wire logic rtc_fault_i,
   input wire logic [N_OUT-1:0] out_o,
   input wire logic [7:0] status_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Status word follows fault inputs; bus three and four bits stay clear; state after reset
   // ----------------------------------------
   property p_pwr; pwr_fault_i |-> ##[1:3] status_o[4]; endproperty
   a_pwr: assert property (p_pwr) else $error("power bit missing");
   property p_misc; misc_fault_i |-> ##[1:3] status_o[5]; endproperty
   a_misc: assert property (p_misc) else $error("misc bit missing");
   property p_rtc; rtc_fault_i |-> ##[1:3] status_o[6]; endproperty
   a_rtc: assert property (p_rtc) else $error("clock bit missing");
   property p_all; (pwr_fault_i && misc_fault_i && rtc_fault_i) [*3] |-> status_o[6:4] == 3'h7;
   endproperty
   a_all: assert property (p_all) else $error("faults not combined");
   property p_misc_clr; !misc_fault_i [*3] |-> !status_o[5]; endproperty
   a_misc_clr: assert property (p_misc_clr) else $error("misc bit stuck");
   property p_rtc_clr; !rtc_fault_i [*3] |-> !status_o[6]; endproperty
   a_rtc_clr: assert property (p_rtc_clr) else $error("clock bit stuck");
   property p_bus34; status_o[3:2] == 2'h0; endproperty
   a_bus34: assert property (p_bus34) else $error("bus three or four flagged");
   property p_rst; $fell(rst_i) |-> out_o == '0 && status_o == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("outputs live after reset");
endmodule : ecs_properties
bind ecs_top ecs_properties #(.N_OUT(N_OUT)) u_ecs_properties (.clk_i(clk_i), .rst_i(rst_i),
   .pwr_fault_i(pwr_fault_i), .misc_fault_i(misc_fault_i), .rtc_fault_i(rtc_fault_i),
   .out_o(out_o), .status_o(status_o));
`default_nettype wire

/* File: dv/ecs_partner.sv */
// CAN node model: sends one channel value every PER cycles while enabled.
// Assumes the bench's clock; the value line toggles between messages.
`timescale 1ns/1ps
`default_nettype none
module ecs_partner #(
   parameter int unsigned PER = 20
) (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic [15:0] val_i,
   output logic [15:0] can_val_o,
   output logic can_upd_o
);
   int cnt_q = 0;
   logic upd_q = 1'b0;
   logic [15:0] val_q = 16'h0000;
   // Message period two fifths of the loss interval
   always @(posedge clk_i)
   begin
      cnt_q <= (cnt_q >= PER - 1) ? 0 : cnt_q + 1;
      upd_q <= en_i && cnt_q == 0;
      val_q <= (en_i && cnt_q == 0) ? val_i : ~val_q;
   end
   assign can_val_o = val_q;
   assign can_upd_o = upd_q;
endmodule : ecs_partner
`default_nettype wire

/* File: dv/test_event_condition_supervisor.sv */
// Bench for ecs_top: Wishbone tasks and call sequences with expected values.
// Assumes ecs_properties is bound and ecs_partner acts as CAN node.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
   $display("CHECK FAILED %0t mismatch", $time); end end
`define WAITU(c) begin checks_done++; n = 0; \
   while (!(c) && n < 20000) begin @(posedge clk_i); n++; end \
   if (!(c)) begin errors++; $display("CHECK FAILED %0t wait timeout", $time); end_of_test(); end end
module test_event_condition_supervisor;
   import ecs_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, en = 0, pwr = 0, misc = 0, rtc = 0;
   logic [15:0] adr = 0, vbat = 16'd12000, dl = 0, dop = 0, pv;
   logic [255:0] ain = 0;
   logic [31:0] dat = 0, q, rd, out;
   logic [3:0] sel = 0;
   logic [7:0] st;
   logic pu, ack, lamp;
   int errors = 0, checks_done = 0, n;
   always #50 clk_i = ~clk_i;
   ecs_top #(.UV_MS(5), .TICK_CYC(600), .FLASH_MS(2)) u_ecs_top (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack), .ain_i(ain), .cur_i(ain),
      .flt_i(ain), .cnt_i(ain), .tmp_i(ain), .can_val_i({240'h0, pv}), .can_upd_i({15'h0, pu}),
      .can_bus_i('0), .din_lvl_i(dl), .din_open_i(dop), .vbat_mv_i(vbat), .pwr_fault_i(pwr),
      .misc_fault_i(misc), .rtc_fault_i(rtc), .out_o(out), .status_o(st), .lamp_o(lamp));
   ecs_partner #(.PER(1200)) u_ecs_partner (.clk_i(clk_i), .en_i(en), .val_i(16'h0007),
      .can_val_o(pv), .can_upd_o(pu));
   // One Wishbone cycle; read data in q
   task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
      k = 0;
      do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
      q = rd;
      cyc <= 0; stb <= 0;
      if (k >= 50) `WAITU(1'b0)
   endtask : wb
   task rdc(input logic [15:0] a, input logic [31:0] e);
      wb(0, a, 32'h0);
      `CHK(q, e)
   endtask : rdc
   function logic [127:0] ev(logic [3:0] t, logic [2:0] s, logic [2:0] on, logic [2:0] off,
      logic [1:0] l, logic [7:0] o, logic [15:0] kon, logic [15:0] koff, logic [15:0] ms);
      ev = {3'h0, ms, 45'h0, koff, kon, o, 1'h0, l, off, on, 8'h0, s, t};
   endfunction : ev
   // Four staged words, then a commit
   task cfg(input logic [8:0] i, input logic [127:0] w);
      for (int j = 0; j < 4; j++) wb(1, 16'(4 * j), w[32*j+:32]);
      wb(1, ECS_A_SEL, {23'h400000, i});
   endtask : cfg
   task end_of_test;
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      rdc(ECS_A_VMIN, 32'h1770);
      rdc(ECS_A_VMAX, 32'h5dc0);
      rdc(16'h0040, 32'h0);
      cfg(0, ev(ECS_T_FOLLOW, ECS_S_AIN, ECS_OP_GT, ECS_OP_LE, ECS_L_HOLD, 8'h1, 100, 100, 1));
      cfg(1, ev(ECS_T_FOLLOW, ECS_S_CAN, ECS_OP_GE, ECS_OP_LT, ECS_L_OFF, 8'h2, 5, 5, 5));
      cfg(2, ev(ECS_T_FOLLOW, ECS_S_AIN, ECS_OP_GE, ECS_OP_LT, ECS_L_HOLD, 8'h0, 1, 1, 1));
      ain <= 256'd101;
      `WAITU(out[0] === 1'b1)
      ain <= 256'd100;
      `WAITU(out[0] === 1'b0)
      wb(1, ECS_A_LAMP, 32'h1);
      en <= 1;
      `WAITU(out[1] === 1'b1)
      `CHK(st[0], 1'b0)
      `CHK(out[31:2], 30'h0)
      en <= 0;
      `WAITU(out[1] === 1'b0)
      `WAITU(st[0] === 1'b1)
      wb(1, ECS_A_LAMP, 32'h0);
      `WAITU(st[0] === 1'b0)
      pwr <= 1; misc <= 1; rtc <= 1;
      `WAITU(st[6:4] === 3'h7)
      `WAITU(lamp === 1'b1)
      pwr <= 0; misc <= 0; rtc <= 0;
      `WAITU(st[6:4] === 3'h0)
      wb(1, ECS_A_VMIN, 32'd24000);
      `WAITU(st[7] === 1'b1)
      wb(1, ECS_A_VMIN, 32'h1770);
      `WAITU(st[7] === 1'b0)
      wb(1, ECS_A_SEL, 32'h3);
      dop <= 16'h0008;
      rdc(ECS_A_DIN, 32'h0);
      dop <= 16'h0000;
      rdc(ECS_A_DIN, 32'h1);
      dl <= 16'h0008;
      rdc(ECS_A_DIN, 32'h2);
      ain <= 256'd101;
      `WAITU(out[0] === 1'b1)
      vbat <= 16'd5999;
      repeat (1500) @(posedge clk_i);
      vbat <= 16'd12000;
      repeat (600) @(posedge clk_i);
      `CHK(out[0], 1'b1)
      vbat <= 16'd5999;
      `WAITU(out === 32'h0 && st[4] === 1'b1)
      vbat <= 16'd6500;
      repeat (3600) @(posedge clk_i);
      `CHK(out[0], 1'b0)
      vbat <= 16'd6501;
      `WAITU(out[0] === 1'b1)
      end_of_test();
   end
endmodule : test_event_condition_supervisor
`default_nettype wire
